//--- hw/uspc_serial_port.sv
`timescale 1ns/10ps
// How it works
// - bit 7 reads and writes as mode low bit or frame fault, per view select
// - frame fault set by a bad stop bit, held until software clears it
// - modes 2 and 3 with filter set: no receive-done when ninth bit is 0
// - mode 1 with filter set: no receive-done without a valid stop bit
// - mode 0 shift clock is oscillator over 12, or over 4 with filter set
// - reception runs only while receive enable is 1
// - modes 2 and 3 send the software ninth bit as ninth data bit
// - modes 2 and 3 store the received ninth data bit, except a 0 with filter set
// - mode 1 with filter clear stores the stop bit as received ninth bit
// - transmit-done set after 8th bit in mode 0, at stop start otherwise
// - receive-done set after 8th bit in mode 0, at mid stop otherwise
// - mode bits select sync 8, async 10, fixed 11 or variable 11 bit frames
// - data address reads the receive buffer and writes start transmission
module uspc_serial_port import uspc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic frame_fault_view_select_i,
  input wire logic double_rate_i,
  input wire logic baud_tick_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o,
  output logic serial_irq_o
);
  // ****************************************************
  // control register state
  // ****************************************************
  logic mode_low_q;
  logic frame_fault_q;
  logic mode_high_bit_q;
  logic address_filter_enable_q;
  logic receive_enable_q;
  logic transmit_ninth_bit_q;
  logic received_ninth_bit_q;
  logic transmit_done_flag_q;
  logic receive_done_flag_q;
  logic [7:0] rx_buf_q;
  logic [7:0] sfr_rdata_q;
  logic irq_q;
  uspc_mode_e mode;

  logic wr_ctrl;
  logic wr_data;
  logic rd_ctrl_any;
  logic [7:0] ctrl_view;

  // hardware events
  logic ti_set;
  logic ri_set;
  logic fe_set;
  logic rx_load;
  logic [7:0] rx_load_data;
  logic rx9_load;
  logic rx9_value;

  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == USPC_CTRL_ADDR);
  assign wr_data = sfr_wr_i && (sfr_addr_i == USPC_DATA_ADDR);
  assign rd_ctrl_any = sfr_rd_i && (sfr_addr_i == USPC_CTRL_ADDR);
  assign mode = uspc_mode_e'({mode_high_bit_q, mode_low_q});

  always_comb begin
    ctrl_view = USPC_CTRL_RESET;
    ctrl_view[USPC_MODE_LOW_OR_FRAME_FAULT] = frame_fault_view_select_i ? frame_fault_q : mode_low_q;
    ctrl_view[USPC_MODE_HIGH_BIT] = mode_high_bit_q;
    ctrl_view[USPC_ADDRESS_FILTER_ENABLE] = address_filter_enable_q;
    ctrl_view[USPC_RECEIVE_ENABLE] = receive_enable_q;
    ctrl_view[USPC_TRANSMIT_NINTH_BIT] = transmit_ninth_bit_q;
    ctrl_view[USPC_RECEIVED_NINTH_BIT] = received_ninth_bit_q;
    ctrl_view[USPC_TRANSMIT_DONE_FLAG] = transmit_done_flag_q;
    ctrl_view[USPC_RECEIVE_DONE_FLAG] = receive_done_flag_q;
  end

  // ****************************************************
  // software writes, hardware sets win over clears
  // ****************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_low_q <= 1'b0;
      frame_fault_q <= 1'b0;
      mode_high_bit_q <= 1'b0;
      address_filter_enable_q <= 1'b0;
      receive_enable_q <= 1'b0;
      transmit_ninth_bit_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        if (frame_fault_view_select_i) begin
          frame_fault_q <= sfr_wdata_i[USPC_MODE_LOW_OR_FRAME_FAULT] || fe_set;
        end else begin
          mode_low_q <= sfr_wdata_i[USPC_MODE_LOW_OR_FRAME_FAULT];
          frame_fault_q <= frame_fault_q || fe_set;
        end
        mode_high_bit_q <= sfr_wdata_i[USPC_MODE_HIGH_BIT];
        address_filter_enable_q <= sfr_wdata_i[USPC_ADDRESS_FILTER_ENABLE];
        receive_enable_q <= sfr_wdata_i[USPC_RECEIVE_ENABLE];
        transmit_ninth_bit_q <= sfr_wdata_i[USPC_TRANSMIT_NINTH_BIT];
      end else if (fe_set) begin
        frame_fault_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transmit_done_flag_q <= 1'b0;
      receive_done_flag_q <= 1'b0;
      received_ninth_bit_q <= 1'b0;
    end else if (ce_i) begin
      transmit_done_flag_q <= ti_set || (wr_ctrl ? sfr_wdata_i[USPC_TRANSMIT_DONE_FLAG] : transmit_done_flag_q);
      receive_done_flag_q <= ri_set || (wr_ctrl ? sfr_wdata_i[USPC_RECEIVE_DONE_FLAG] : receive_done_flag_q);
      if (rx9_load) begin
        received_ninth_bit_q <= rx9_value;
      end else if (wr_ctrl) begin
        received_ninth_bit_q <= sfr_wdata_i[USPC_RECEIVED_NINTH_BIT];
      end
    end
  end

  // ****************************************************
  // read port, receive buffer and interrupt
  // ****************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_q <= USPC_READ_NONE;
      rx_buf_q <= USPC_DATA_RESET;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      if (rd_ctrl_any) begin
        sfr_rdata_q <= ctrl_view;
      end else if (sfr_rd_i && sfr_addr_i == USPC_DATA_ADDR) begin
        sfr_rdata_q <= rx_buf_q;
      end else if (sfr_rd_i) begin
        sfr_rdata_q <= USPC_READ_NONE;
      end
      if (rx_load) begin
        rx_buf_q <= rx_load_data;
      end
      irq_q <= transmit_done_flag_q || receive_done_flag_q;
    end
  end

  // ****************************************************
  // bit rate ticks
  // ****************************************************
  logic m0_act_q;
  logic m0_rx_q;
  logic [2:0] m0_bit_q;
  logic [7:0] m0_shift_q;
  logic m0_tick;
  logic m0_first_half;
  logic m2_tick;
  logic samp_tick;

  uspc_tick_div #(.W(4)) u_m0_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(!m0_act_q),
    .divisor_i(address_filter_enable_q ? USPC_M0_DIV_FAST : USPC_M0_DIV_SLOW),
    .tick_o(m0_tick),
    .first_half_o(m0_first_half)
  );

  uspc_tick_div #(.W(4)) u_m2_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(1'b0),
    .divisor_i(double_rate_i ? USPC_M2_SAMP_FAST : USPC_M2_SAMP_SLOW),
    .tick_o(m2_tick),
    .first_half_o()
  );

  assign samp_tick = ce_i && ((mode == USPC_MODE_FIX11) ? m2_tick : baud_tick_i);

  // ****************************************************
  // mode 0 synchronous shifter
  // ****************************************************
  logic m0_tx_start;
  logic m0_rx_start;
  logic m0_end;
  uspc_state_e tx_state_q;
  uspc_state_e rx_state_q;

  assign m0_tx_start = wr_data && (mode == USPC_MODE_SYNC8) && !m0_act_q;
  assign m0_rx_start = (mode == USPC_MODE_SYNC8) && !m0_act_q && !wr_data && receive_enable_q
                       && !receive_done_flag_q;
  assign m0_end = m0_act_q && m0_tick && (m0_bit_q == USPC_M0_LAST_BIT);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m0_act_q <= 1'b0;
      m0_rx_q <= 1'b0;
      m0_bit_q <= '0;
      m0_shift_q <= '0;
    end else if (ce_i) begin
      if (m0_tx_start) begin
        m0_act_q <= 1'b1;
        m0_rx_q <= 1'b0;
        m0_bit_q <= '0;
        m0_shift_q <= sfr_wdata_i;
      end else if (m0_rx_start) begin
        m0_act_q <= 1'b1;
        m0_rx_q <= 1'b1;
        m0_bit_q <= '0;
      end else if (m0_act_q && m0_rx_q && !receive_enable_q) begin
        m0_act_q <= 1'b0;
      end else if (m0_act_q && m0_tick) begin
        m0_bit_q <= m0_bit_q + 3'h1;
        m0_shift_q <= {m0_rx_q ? rxd_i : 1'b1, m0_shift_q[7:1]};
        if (m0_end) begin
          m0_act_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************
  // asynchronous transmitter
  // ****************************************************
  logic [10:0] tx_shift_q;
  logic [3:0] tx_samp_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_len;
  logic tx_start;
  logic txd_q;
  logic rxd_q;
  logic rxd_oe_q;

  assign tx_len = (mode == USPC_MODE_ASYNC10) ? USPC_LEN_10 : USPC_LEN_11;
  assign tx_start = wr_data && (mode != USPC_MODE_SYNC8) && (tx_state_q == USPC_IDLE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= USPC_IDLE;
      tx_shift_q <= '1;
      tx_samp_q <= '0;
      tx_bit_q <= '0;
    end else if (ce_i) begin
      case (tx_state_q)
        USPC_IDLE: begin
          if (tx_start) begin
            tx_state_q <= USPC_RUN;
            tx_samp_q <= '0;
            tx_bit_q <= '0;
            if (mode == USPC_MODE_ASYNC10) begin
              tx_shift_q <= {2'b11, sfr_wdata_i, 1'b0};
            end else begin
              tx_shift_q <= {1'b1, transmit_ninth_bit_q, sfr_wdata_i, 1'b0};
            end
          end
        end
        USPC_RUN: begin
          if (samp_tick) begin
            tx_samp_q <= tx_samp_q + 4'h1;
            if (tx_samp_q == USPC_SAMP_LAST) begin
              tx_shift_q <= {1'b1, tx_shift_q[10:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == tx_len - 4'h1) begin
                tx_state_q <= USPC_IDLE;
              end
            end
          end
        end
        default: begin
          tx_state_q <= USPC_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // asynchronous receiver
  // ****************************************************
  logic rxd_prev_q;
  logic [3:0] rx_samp_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_data_q;
  logic rx_ninth_q;
  logic rx_mid;
  logic rx_stop;
  logic rx_accept;
  logic [7:0] tx_view;

  assign rx_mid = (rx_state_q == USPC_RUN) && samp_tick && (rx_samp_q == USPC_SAMP_MID);
  assign rx_stop = rx_mid && (rx_bit_q == tx_len - 4'h1);

  always_comb begin
    rx_accept = 1'b1;
    if (mode == USPC_MODE_ASYNC10) begin
      rx_accept = !(address_filter_enable_q && !rxd_i);
    end else begin
      rx_accept = !(address_filter_enable_q && !rx_ninth_q);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_q <= USPC_IDLE;
      rxd_prev_q <= 1'b1;
      rx_samp_q <= '0;
      rx_bit_q <= '0;
      rx_data_q <= '0;
      rx_ninth_q <= 1'b0;
    end else if (ce_i) begin
      rxd_prev_q <= rxd_i;
      case (rx_state_q)
        USPC_IDLE: begin
          if (receive_enable_q && mode != USPC_MODE_SYNC8 && rxd_prev_q && !rxd_i) begin
            rx_state_q <= USPC_RUN;
            rx_samp_q <= '0;
            rx_bit_q <= '0;
          end
        end
        USPC_RUN: begin
          if (!receive_enable_q || mode == USPC_MODE_SYNC8) begin
            rx_state_q <= USPC_IDLE;
          end else if (samp_tick) begin
            rx_samp_q <= rx_samp_q + 4'h1;
            if (rx_samp_q == USPC_SAMP_LAST) begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
            if (rx_mid) begin
              if (rx_bit_q == 4'h0 && rxd_i) begin
                rx_state_q <= USPC_IDLE;
              end else if (rx_stop) begin
                rx_state_q <= USPC_IDLE;
              end else if (rx_bit_q == 4'h9) begin
                rx_ninth_q <= rxd_i;
              end else if (rx_bit_q != 4'h0) begin
                rx_data_q <= {rxd_i, rx_data_q[7:1]};
              end
            end
          end
        end
        default: begin
          rx_state_q <= USPC_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // event decode and pins
  // ****************************************************
  assign ti_set = ce_i && ((m0_end && !m0_rx_q) || ((tx_state_q == USPC_RUN) && samp_tick
                  && tx_samp_q == USPC_SAMP_LAST && tx_bit_q == tx_len - 4'h2));
  assign fe_set = ce_i && rx_stop && !rxd_i;
  assign ri_set = ce_i && ((m0_end && m0_rx_q) || (rx_stop && rx_accept));
  assign rx_load = ri_set;
  assign rx_load_data = m0_end ? {rxd_i, m0_shift_q[7:1]} : rx_data_q;
  assign rx9_load = ce_i && rx_stop && rx_accept && !(mode == USPC_MODE_ASYNC10 && address_filter_enable_q);
  assign rx9_value = (mode == USPC_MODE_ASYNC10) ? rxd_i : rx_ninth_q;
  assign tx_view = m0_shift_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_q <= 1'b1;
      rxd_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else if (ce_i) begin
      if (m0_act_q) begin
        txd_q <= !m0_first_half;
        rxd_q <= tx_view[0];
        rxd_oe_q <= !m0_rx_q;
      end else begin
        txd_q <= (tx_state_q == USPC_RUN) ? tx_shift_q[0] : 1'b1;
        rxd_q <= 1'b1;
        rxd_oe_q <= 1'b0;
      end
    end
  end

  assign sfr_rdata_o = sfr_rdata_q;
  assign txd_o = txd_q;
  assign rxd_o = rxd_q;
  assign rxd_oe_o = rxd_oe_q;
  assign serial_irq_o = irq_q;
endmodule // uspc_serial_port

//--- hw/uspc_pkg.sv
package uspc_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] USPC_CTRL_ADDR = 8'h98;
  localparam logic [7:0] USPC_DATA_ADDR = 8'h99;
  localparam logic [7:0] USPC_CTRL_RESET = 8'h00;
  localparam logic [7:0] USPC_DATA_RESET = 8'h00;
  localparam logic [7:0] USPC_READ_NONE = 8'h00;

  // ****************************************************
  // control register fields
  // ****************************************************
  localparam int USPC_MODE_LOW_OR_FRAME_FAULT = 7;
  localparam int USPC_MODE_HIGH_BIT = 6;
  localparam int USPC_ADDRESS_FILTER_ENABLE = 5;
  localparam int USPC_RECEIVE_ENABLE = 4;
  localparam int USPC_TRANSMIT_NINTH_BIT = 3;
  localparam int USPC_RECEIVED_NINTH_BIT = 2;
  localparam int USPC_TRANSMIT_DONE_FLAG = 1;
  localparam int USPC_RECEIVE_DONE_FLAG = 0;

  // ****************************************************
  // timing counts
  // ****************************************************
  localparam logic [3:0] USPC_M0_DIV_SLOW = 4'hC;
  localparam logic [3:0] USPC_M0_DIV_FAST = 4'h4;
  localparam logic [3:0] USPC_M2_SAMP_SLOW = 4'h4;
  localparam logic [3:0] USPC_M2_SAMP_FAST = 4'h2;
  localparam logic [3:0] USPC_SAMP_LAST = 4'hF;
  localparam logic [3:0] USPC_SAMP_MID = 4'h7;
  localparam logic [3:0] USPC_LEN_10 = 4'hA;
  localparam logic [3:0] USPC_LEN_11 = 4'hB;
  localparam logic [2:0] USPC_M0_LAST_BIT = 3'h7;

  // ****************************************************
  // modes, encoded as {mode_high_bit, mode_low}
  // ****************************************************
  typedef enum logic [1:0] {
    USPC_MODE_SYNC8,
    USPC_MODE_ASYNC10,
    USPC_MODE_FIX11,
    USPC_MODE_VAR11
  } uspc_mode_e;

  typedef enum logic {
    USPC_IDLE,
    USPC_RUN
  } uspc_state_e;
endpackage

//--- hw/uspc_tick_div.sv
`timescale 1ns/10ps
module uspc_tick_div import uspc_pkg::*; #(
  parameter int W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic [W-1:0] divisor_i,
  output logic tick_o,
  output logic first_half_o
);
  // ****************************************************
  // free divider, restarted by clear
  // ****************************************************
  logic [W-1:0] cnt_q;
  logic [W-1:0] last;

  assign last = divisor_i - W'(1);
  assign tick_o = ce_i && !clear_i && (cnt_q == last);
  assign first_half_o = cnt_q < (divisor_i >> 1);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (clear_i || cnt_q == last) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end
endmodule // uspc_tick_div

//--- testbench/uspc_serial_port_asserts.sv
`timescale 1ns/10ps
module uspc_serial_port_asserts import uspc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic frame_fault_view_select_i,
  input wire logic rxd_oe_o,
  input wire logic txd_o,
  input wire logic serial_irq_o
);
  // ****
  // shadow of mode and filter bits
  // ****
  logic [1:0] mode_q;
  logic filt_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= 2'h0;
      filt_q <= 1'b0;
    end else if (ce_i && sfr_wr_i && sfr_addr_i == USPC_CTRL_ADDR) begin
      mode_q[1] <= sfr_wdata_i[USPC_MODE_HIGH_BIT];
      if (!frame_fault_view_select_i) begin
        mode_q[0] <= sfr_wdata_i[USPC_MODE_LOW_OR_FRAME_FAULT];
      end
      filt_q <= sfr_wdata_i[USPC_ADDRESS_FILTER_ENABLE];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  a_reset_idle_out: assert property ($fell(rst_i) |-> txd_o && !rxd_oe_o && !serial_irq_o)
    else $error("outputs not idle after reset");
  a_unmapped_read: assert property (ce_i && sfr_rd_i && sfr_addr_i != USPC_CTRL_ADDR &&
    sfr_addr_i != USPC_DATA_ADDR |=> sfr_rdata_o == USPC_READ_NONE)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!(ce_i && sfr_rd_i) |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");
  a_irq_flags_match: assert property (ce_i && sfr_rd_i && sfr_addr_i == USPC_CTRL_ADDR |=>
    serial_irq_o == (|sfr_rdata_o[1:0]))
    else $error("irq differs from done flags");
  a_irq_sw_clear: assert property ($fell(serial_irq_o) |->
    $past(ce_i && sfr_wr_i && sfr_addr_i == USPC_CTRL_ADDR, 2))
    else $error("irq fell without control write");
  a_tx_done_stop: assert property ($rose(serial_irq_o) && mode_q != 2'h0 |-> txd_o)
    else $error("done flag outside stop time");
  a_oe_mode_zero: assert property (rxd_oe_o |-> mode_q == 2'h0)
    else $error("pin driven outside sync mode");
  a_m0_slow_clk: assert property ($fell(txd_o) && mode_q == 2'h0 && !filt_q |->
    !txd_o [*6] ##1 txd_o)
    else $error("slow shift clock wrong");
  a_m0_fast_clk: assert property ($fell(txd_o) && mode_q == 2'h0 && filt_q |->
    !txd_o [*2] ##1 txd_o)
    else $error("fast shift clock wrong");
endmodule // uspc_serial_port_asserts

bind uspc_serial_port uspc_serial_port_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .frame_fault_view_select_i(frame_fault_view_select_i),
  .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .serial_irq_o(serial_irq_o));

//--- testbench/uspc_serial_peer.sv
`timescale 1ns/10ps
module uspc_serial_peer (
  input wire logic ref_clk_i,
  input wire logic baud_tick_i,
  input wire logic txd_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic bit_time(input int n);
    repeat (n) @(posedge ref_clk_i iff baud_tick_i);
  endtask
  // ****
  // frames: start, data lsb first, stop; 16 ticks a bit
  // ****
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    bit_time(1);
    line_o <= 1'b0;
    bit_time(16);
    for (int i = 0; i < nb; i++) begin
      line_o <= d[i];
      bit_time(16);
    end
    line_o <= stop;
    bit_time(16);
    line_o <= 1'b1;
  endtask
  task automatic rcv(output logic [8:0] d, input int nb, output logic stop);
    d = 9'h000;
    wait (txd_i === 1'b0);
    bit_time(8);
    for (int i = 0; i < nb; i++) begin
      bit_time(16);
      d[i] = txd_i;
    end
    bit_time(16);
    stop = txd_i;
  endtask
endmodule // uspc_serial_peer

//--- testbench/uspc_serial_port_tb_top.sv
`timescale 1ns/10ps
module uspc_serial_port_tb_top import uspc_pkg::*; ;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic view_sel = 1'b0;
  logic baud_tick_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic rxd_o, rxd_oe_o, txd_o, serial_irq_o, peer_line, rxd_pin, stop;
  logic [1:0] tick_cnt = 2'h0;
  logic [8:0] got;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  assign rxd_pin = rxd_oe_o ? rxd_o : peer_line;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    baud_tick_i <= (tick_cnt == 2'h3);
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  uspc_serial_port dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .frame_fault_view_select_i(view_sel), .double_rate_i(1'b0), .baud_tick_i(baud_tick_i),
    .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .serial_irq_o(serial_irq_o));
  uspc_serial_peer peer (.ref_clk_i(ref_clk_i), .baud_tick_i(baud_tick_i), .txd_i(txd_o), .line_o(peer_line));
  // ****
  // access tasks
  // ****
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    #1 chk("rdata", {1'b0, exp}, {1'b0, sfr_rdata_o});
  endtask
  task automatic view(input logic v);
    @(posedge ref_clk_i);
    view_sel <= v;
  endtask
  task automatic m0tx(input logic [7:0] ctrl, input logic [7:0] d);
    logic [7:0] cap;
    wr(USPC_CTRL_ADDR, ctrl);
    wr(USPC_DATA_ADDR, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_o);
      cap[i] = rxd_o;
    end
    chk("sync data", {1'b0, d}, {1'b0, cap});
    for (int n = 0; n < 100 && serial_irq_o !== 1'b1; n++) @(posedge ref_clk_i);
    rd(USPC_CTRL_ADDR, ctrl | 8'h02);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(USPC_CTRL_ADDR, USPC_CTRL_RESET);
    rd(8'h9A, USPC_READ_NONE);
    wr(USPC_CTRL_ADDR, 8'h40);
    rd(USPC_CTRL_ADDR, 8'h40);
    view(1'b1);
    wr(USPC_CTRL_ADDR, 8'hC0);
    rd(USPC_CTRL_ADDR, 8'hC0);
    view(1'b0);
    rd(USPC_CTRL_ADDR, 8'h40);
    view(1'b1);
    wr(USPC_CTRL_ADDR, 8'h00);
    rd(USPC_CTRL_ADDR, 8'h00);
    view(1'b0);
    wr(USPC_CTRL_ADDR, 8'h80);
    fork
      wr(USPC_DATA_ADDR, 8'hA5);
      peer.rcv(got, 8, stop);
    join
    chk("tx byte", 9'h0A5, got);
    chk("tx stop", 9'h001, {8'h00, stop});
    rd(USPC_CTRL_ADDR, 8'h82);
    chk("irq", 9'h001, {8'h00, serial_irq_o});
    wr(USPC_CTRL_ADDR, 8'h90);
    peer.send(9'h03C, 8, 1'b1);
    rd(USPC_CTRL_ADDR, 8'h95);
    rd(USPC_DATA_ADDR, 8'h3C);
    wr(USPC_CTRL_ADDR, 8'hB0);
    peer.send(9'h055, 8, 1'b0);
    view(1'b1);
    rd(USPC_CTRL_ADDR, 8'hB0);
    rd(USPC_DATA_ADDR, 8'h3C);
    wr(USPC_CTRL_ADDR, 8'h30);
    rd(USPC_CTRL_ADDR, 8'h30);
    view(1'b0);
    rd(USPC_CTRL_ADDR, 8'hB0);
    wr(USPC_CTRL_ADDR, 8'hF0);
    peer.send(9'h012, 9, 1'b1);
    rd(USPC_CTRL_ADDR, 8'hF0);
    peer.send(9'h134, 9, 1'b1);
    rd(USPC_CTRL_ADDR, 8'hF5);
    rd(USPC_DATA_ADDR, 8'h34);
    wr(USPC_CTRL_ADDR, 8'hE8);
    fork
      wr(USPC_DATA_ADDR, 8'h96);
      peer.rcv(got, 9, stop);
    join
    chk("tx ninth", 9'h196, got);
    rd(USPC_CTRL_ADDR, 8'hEA);
    peer.send(9'h177, 9, 1'b1);
    rd(USPC_CTRL_ADDR, 8'hEA);
    rd(USPC_DATA_ADDR, 8'h34);
    wr(USPC_CTRL_ADDR, 8'h50);
    peer.send(9'h1A5, 9, 1'b1);
    rd(USPC_CTRL_ADDR, 8'h55);
    rd(USPC_DATA_ADDR, 8'hA5);
    m0tx(8'h00, 8'h5A);
    m0tx(8'h20, 8'hC3);
    wr(USPC_CTRL_ADDR, 8'h10);
    repeat (3) @(posedge ref_clk_i);
    for (int n = 0; n < 200 && serial_irq_o !== 1'b1; n++) @(posedge ref_clk_i);
    rd(USPC_CTRL_ADDR, 8'h11);
    rd(USPC_DATA_ADDR, 8'hFF);
    conclude();
  end
endmodule // uspc_serial_port_tb_top
